//--- hdl/swh_cfg.svh
// timing constants and chosen operating points of the single-wire port
// assumes a 125 MHz sys_clk; included by the package and both ends
`ifndef SWH_CFG_SVH
`define SWH_CFG_SVH

// ----------------------------------------------------------------
// clock and widths
// ----------------------------------------------------------------
`define SWH_CLK_MHZ 125
`define SWH_CNT_W 29

// ----------------------------------------------------------------
// link limits
// ----------------------------------------------------------------
`define SWH_BREAK_LOW_US 190
`define SWH_BREAK_REL_US 40
`define SWH_HOST_ONE_MIN_NS 500
`define SWH_HOST_ONE_MAX_US 50
`define SWH_HOST_ZERO_MIN_US 86
`define SWH_HOST_ZERO_MAX_US 145
`define SWH_HOST_PERIOD_MIN_US 190
`define SWH_REPLY_DELAY_MIN_US 190
`define SWH_REPLY_DELAY_MAX_US 950
`define SWH_REPLY_ONE_MIN_US 32
`define SWH_REPLY_ONE_MAX_US 50
`define SWH_REPLY_ZERO_MIN_US 80
`define SWH_REPLY_ZERO_MAX_US 145
`define SWH_REPLY_PERIOD_MIN_US 190
`define SWH_REPLY_PERIOD_NOM_US 205
`define SWH_REPLY_PERIOD_MAX_US 250
`define SWH_TURN_MIN_US 250
`define SWH_RESET_LOW_MS 2200

// ----------------------------------------------------------------
// operating points inside the limits
// ----------------------------------------------------------------
`define SWH_DEV_DELAY_US 300
`define SWH_DEV_ONE_US 40
`define SWH_DEV_ZERO_US 112
`define SWH_DEV_THRESH_US 68
`define SWH_HOST_ONE_US 10
`define SWH_HOST_ZERO_US 115
`define SWH_HOST_BIT_US 200
`define SWH_HOST_THRESH_US 65

// ----------------------------------------------------------------
// conversions to cycles
// ----------------------------------------------------------------
`define SWH_US2CYC(t) ((t) * `SWH_CLK_MHZ)
`define SWH_MS2CYC(t) ((t) * `SWH_CLK_MHZ * 1000)

`endif

//--- hdl/swh_pkg.sv
// types shared by both ends of the single-wire port
// assumes swh_cfg.svh is on the include path
`include "swh_cfg.svh"

package swh_pkg;
	typedef logic [`SWH_CNT_W-1:0] swh_cnt_t;
	typedef logic [6:0] swh_addr_t;
	typedef logic [7:0] swh_byte_t;

	typedef enum logic [2:0] {
		D_IDLE = 3'h0,
		D_BRK = 3'h1,
		D_RX = 3'h3,
		D_RX_LOW = 3'h2,
		D_DELAY = 3'h6,
		D_TX_LOW = 3'h7,
		D_TX_HIGH = 3'h5
	} swh_dev_st_e;

	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_BRK = 3'h1,
		H_BRK_REL = 3'h3,
		H_TX_LOW = 3'h2,
		H_TX_HIGH = 3'h6,
		H_WAIT_RSP = 3'h7,
		H_RX_LOW = 3'h5,
		H_TURN = 3'h4
	} swh_host_st_e;
endpackage

//--- hdl/swh_if.sv
// the shared open-drain line between host end and device end
// assumes an external pull-up: released line reads high
`timescale 1ns/10ps
`default_nettype none

interface swh_if;
	logic dev_line_o;
	logic dev_line_oe_n;
	logic host_line_o;
	logic host_line_oe_n;
	logic line;

	assign line = ~((~dev_line_oe_n & ~dev_line_o) |
		(~host_line_oe_n & ~host_line_o));

	modport dev(input line, output dev_line_o, output dev_line_oe_n);
	modport host(input line, output host_line_o, output host_line_oe_n);
endinterface

`default_nettype wire

//--- hdl/swh_dev.sv
// device end of the single-wire host port
// assumes one 125 MHz clock; the line arrives asynchronously
//
// Summary of operation
// - host opens with long break, then release
// - host bit low time encodes one or zero
// - host bit period at least the minimum
// - device waits bounded delay before replying
// - device reply low time encodes the bit
// - device reply bit period within limits
// - host waits turnaround before driving again
// - very long low resets the device
// - single-wire mode shares the data pin
// - single-wire mode, once set, holds until sys_rst
`timescale 1ns/10ps
`default_nettype none
`include "swh_cfg.svh"

module swh_dev #(
	parameter int BREAK_CYC = `SWH_US2CYC(`SWH_BREAK_LOW_US),
	parameter int THRESH_CYC = `SWH_US2CYC(`SWH_DEV_THRESH_US),
	parameter int DELAY_CYC = `SWH_US2CYC(`SWH_DEV_DELAY_US),
	parameter int ONE_CYC = `SWH_US2CYC(`SWH_DEV_ONE_US),
	parameter int ZERO_CYC = `SWH_US2CYC(`SWH_DEV_ZERO_US),
	parameter int PERIOD_CYC = `SWH_US2CYC(`SWH_REPLY_PERIOD_NOM_US),
	parameter int RESET_CYC = `SWH_MS2CYC(`SWH_RESET_LOW_MS)
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	swh_if.dev lnk,
	input wire logic swire_mode_set,
	input wire swh_pkg::swh_byte_t rd_data,
	output logic swire_mode,
	output logic rd_req,
	output logic wr_valid,
	output swh_pkg::swh_addr_t addr,
	output swh_pkg::swh_byte_t wr_data,
	output logic link_reset
);
	import swh_pkg::*;

	// ----------------------------------------------------------------
	// constants
	// ----------------------------------------------------------------
	localparam swh_cnt_t K_BREAK_END = swh_cnt_t'(BREAK_CYC - 1);
	localparam swh_cnt_t K_THRESH = swh_cnt_t'(THRESH_CYC);
	localparam swh_cnt_t K_DELAY_END = swh_cnt_t'(DELAY_CYC - 1);
	localparam swh_cnt_t K_ONE_END = swh_cnt_t'(ONE_CYC - 1);
	localparam swh_cnt_t K_ZERO_END = swh_cnt_t'(ZERO_CYC - 1);
	localparam swh_cnt_t K_PERIOD_END = swh_cnt_t'(PERIOD_CYC - 1);
	localparam swh_cnt_t K_RESET_END = swh_cnt_t'(RESET_CYC - 1);
	localparam swh_cnt_t K_RESET = swh_cnt_t'(RESET_CYC);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		swh_dev_st_e st;
		logic sync1;
		logic sync2;
		logic line_d;
		swh_cnt_t low_cnt;
		swh_cnt_t tmr;
		logic [3:0] nbit;
		logic [15:0] sh;
		logic swire_mode;
		logic oe_n;
		logic rd_req;
		logic wr_valid;
		swh_addr_t addr;
		swh_byte_t wr_data;
		logic link_reset;
	} swh_dev_s;

	localparam swh_dev_s DEV_RST = '{
		st: D_IDLE,
		sync1: 1'b1,
		sync2: 1'b1,
		line_d: 1'b1,
		oe_n: 1'b1,
		default: '0
	};

	swh_dev_s r_reg;
	swh_dev_s r_next;
	logic fell;
	logic rose;
	logic rx_bit;
	logic [15:0] rx_sh;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.sync1 = lnk.line;
		r_next.sync2 = r_reg.sync1;
		r_next.line_d = r_reg.sync2;
		r_next.rd_req = 1'b0;
		r_next.wr_valid = 1'b0;
		r_next.link_reset = 1'b0;
		fell = r_reg.line_d & ~r_reg.sync2;
		rose = ~r_reg.line_d & r_reg.sync2;
		// a short low pulse means one
		rx_bit = r_reg.tmr < K_THRESH;
		rx_sh = {rx_bit, r_reg.sh[15:1]};

		// the mode bit is cleared only by sys_rst, never by a line reset
		if (swire_mode_set) begin
			r_next.swire_mode = 1'b1;
		end

		if (r_reg.tmr != '1) begin
			r_next.tmr = r_reg.tmr + 1'b1;
		end

		// counts our own drive too; reply lows stay far below a break
		if (r_reg.swire_mode && !r_reg.sync2) begin
			if (r_reg.low_cnt != K_RESET) begin
				r_next.low_cnt = r_reg.low_cnt + 1'b1;
			end
		end else begin
			r_next.low_cnt = '0;
		end

		unique case (r_reg.st)
		D_IDLE: begin
		end
		D_BRK: begin
			if (rose) begin
				r_next.st = D_RX;
				r_next.nbit = 4'h0;
			end
		end
		D_RX: begin
			if (fell) begin
				r_next.st = D_RX_LOW;
				r_next.tmr = '0;
			end
		end
		D_RX_LOW: begin
			if (rose) begin
				r_next.sh = rx_sh;
				r_next.nbit = r_reg.nbit + 4'h1;
				r_next.st = D_RX;
				if (r_reg.nbit == 4'h7) begin
					r_next.addr = rx_sh[14:8];
					if (!rx_bit) begin
						// read: user has the whole delay to answer
						r_next.rd_req = 1'b1;
						r_next.st = D_DELAY;
						r_next.tmr = '0;
					end
				end
				if (r_reg.nbit == 4'hF) begin
					r_next.wr_data = rx_sh[15:8];
					r_next.wr_valid = 1'b1;
					r_next.st = D_IDLE;
				end
			end
		end
		D_DELAY: begin
			if (r_reg.tmr == K_DELAY_END) begin
				r_next.sh = {8'h00, rd_data};
				r_next.nbit = 4'h0;
				r_next.tmr = '0;
				r_next.st = D_TX_LOW;
				r_next.oe_n = 1'b0;
			end
		end
		D_TX_LOW: begin
			if (r_reg.tmr == (r_reg.sh[0] ? K_ONE_END : K_ZERO_END)) begin
				r_next.st = D_TX_HIGH;
				r_next.oe_n = 1'b1;
			end
		end
		D_TX_HIGH: begin
			if (r_reg.tmr == K_PERIOD_END) begin
				if (r_reg.nbit == 4'h7) begin
					r_next.st = D_IDLE;
				end else begin
					r_next.nbit = r_reg.nbit + 4'h1;
					r_next.sh = {1'b0, r_reg.sh[15:1]};
					r_next.tmr = '0;
					r_next.st = D_TX_LOW;
					r_next.oe_n = 1'b0;
				end
			end
		end
		default: begin
			r_next.st = D_IDLE;
			r_next.oe_n = 1'b1;
		end
		endcase

		// a break restarts reception from any state
		if (r_reg.low_cnt == K_BREAK_END) begin
			r_next.st = D_BRK;
			r_next.oe_n = 1'b1;
		end

		if (r_reg.low_cnt == K_RESET_END) begin
			r_next.link_reset = 1'b1;
			r_next.st = D_IDLE;
			r_next.oe_n = 1'b1;
		end

		// in i2c mode the shared pin belongs to the i2c slave
		if (!r_reg.swire_mode) begin
			r_next.st = D_IDLE;
			r_next.oe_n = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r_reg <= DEV_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign lnk.dev_line_o = 1'b0;
	assign lnk.dev_line_oe_n = r_reg.oe_n;
	assign swire_mode = r_reg.swire_mode;
	assign rd_req = r_reg.rd_req;
	assign wr_valid = r_reg.wr_valid;
	assign addr = r_reg.addr;
	assign wr_data = r_reg.wr_data;
	assign link_reset = r_reg.link_reset;
endmodule

`default_nettype wire

//--- hdl/swh_host.sv
// host end of the single-wire port
// assumes one 125 MHz clock; the line arrives asynchronously
`timescale 1ns/10ps
`default_nettype none
`include "swh_cfg.svh"

module swh_host #(
	parameter int BREAK_CYC = `SWH_US2CYC(`SWH_BREAK_LOW_US),
	parameter int REL_CYC = `SWH_US2CYC(`SWH_BREAK_REL_US),
	parameter int ONE_CYC = `SWH_US2CYC(`SWH_HOST_ONE_US),
	parameter int ZERO_CYC = `SWH_US2CYC(`SWH_HOST_ZERO_US),
	parameter int BIT_CYC = `SWH_US2CYC(`SWH_HOST_BIT_US),
	parameter int THRESH_CYC = `SWH_US2CYC(`SWH_HOST_THRESH_US),
	parameter int TMO_CYC = `SWH_US2CYC(`SWH_REPLY_DELAY_MAX_US +
		`SWH_REPLY_PERIOD_MAX_US),
	parameter int TURN_CYC = `SWH_US2CYC(`SWH_TURN_MIN_US),
	parameter int RESET_CYC = `SWH_MS2CYC(`SWH_RESET_LOW_MS)
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	swh_if.host lnk,
	input wire logic req_valid,
	input wire logic req_write,
	input wire swh_pkg::swh_addr_t req_addr,
	input wire swh_pkg::swh_byte_t req_data,
	input wire logic force_reset,
	output logic req_ready,
	output logic rsp_valid,
	output swh_pkg::swh_byte_t rsp_data,
	output logic rsp_err
);
	import swh_pkg::*;

	// ----------------------------------------------------------------
	// constants
	// ----------------------------------------------------------------
	localparam swh_cnt_t K_BREAK_END = swh_cnt_t'(BREAK_CYC - 1);
	localparam swh_cnt_t K_REL_END = swh_cnt_t'(REL_CYC - 1);
	localparam swh_cnt_t K_ONE_END = swh_cnt_t'(ONE_CYC - 1);
	localparam swh_cnt_t K_ZERO_END = swh_cnt_t'(ZERO_CYC - 1);
	localparam swh_cnt_t K_BIT_END = swh_cnt_t'(BIT_CYC - 1);
	localparam swh_cnt_t K_THRESH = swh_cnt_t'(THRESH_CYC);
	localparam swh_cnt_t K_TMO_END = swh_cnt_t'(TMO_CYC - 1);
	localparam swh_cnt_t K_TURN_END = swh_cnt_t'(TURN_CYC - 1);
	localparam swh_cnt_t K_RESET_END = swh_cnt_t'(RESET_CYC - 1);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		swh_host_st_e st;
		logic sync1;
		logic sync2;
		logic line_d;
		swh_cnt_t tmr;
		logic [3:0] nbit;
		logic [15:0] sh;
		logic wr;
		logic long_brk;
		logic oe_n;
		logic ready;
		logic rsp_valid;
		swh_byte_t rsp_data;
		logic rsp_err;
	} swh_host_s;

	localparam swh_host_s HOST_RST = '{
		st: H_IDLE,
		sync1: 1'b1,
		sync2: 1'b1,
		line_d: 1'b1,
		oe_n: 1'b1,
		ready: 1'b1,
		default: '0
	};

	swh_host_s r_reg;
	swh_host_s r_next;
	logic fell;
	logic rose;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.sync1 = lnk.line;
		r_next.sync2 = r_reg.sync1;
		r_next.line_d = r_reg.sync2;
		r_next.rsp_valid = 1'b0;
		fell = r_reg.line_d & ~r_reg.sync2;
		rose = ~r_reg.line_d & r_reg.sync2;
		if (r_reg.tmr != '1) begin
			r_next.tmr = r_reg.tmr + 1'b1;
		end

		unique case (r_reg.st)
		H_IDLE: begin
			r_next.tmr = '0;
			r_next.nbit = 4'h0;
			if (force_reset) begin
				r_next.long_brk = 1'b1;
				r_next.st = H_BRK;
				r_next.oe_n = 1'b0;
			end else if (req_valid) begin
				r_next.long_brk = 1'b0;
				r_next.wr = req_write;
				r_next.sh = {req_data, req_write, req_addr};
				r_next.rsp_err = 1'b0;
				r_next.st = H_BRK;
				r_next.oe_n = 1'b0;
			end
		end
		H_BRK: begin
			if (r_reg.tmr == (r_reg.long_brk ? K_RESET_END : K_BREAK_END)) begin
				r_next.st = H_BRK_REL;
				r_next.oe_n = 1'b1;
				r_next.tmr = '0;
			end
		end
		H_BRK_REL: begin
			if (r_reg.tmr == K_REL_END) begin
				r_next.tmr = '0;
				r_next.st = r_reg.long_brk ? H_IDLE : H_TX_LOW;
				r_next.oe_n = r_reg.long_brk;
			end
		end
		H_TX_LOW: begin
			if (r_reg.tmr == (r_reg.sh[0] ? K_ONE_END : K_ZERO_END)) begin
				r_next.st = H_TX_HIGH;
				r_next.oe_n = 1'b1;
			end
		end
		H_TX_HIGH: begin
			if (r_reg.tmr == K_BIT_END) begin
				r_next.tmr = '0;
				if (r_reg.nbit == (r_reg.wr ? 4'hF : 4'h7)) begin
					r_next.nbit = 4'h0;
					r_next.st = r_reg.wr ? H_IDLE : H_WAIT_RSP;
					r_next.rsp_valid = r_reg.wr;
				end else begin
					r_next.nbit = r_reg.nbit + 4'h1;
					r_next.sh = {1'b0, r_reg.sh[15:1]};
					r_next.st = H_TX_LOW;
					r_next.oe_n = 1'b0;
				end
			end
		end
		H_WAIT_RSP: begin
			if (fell) begin
				r_next.st = H_RX_LOW;
				r_next.tmr = '0;
			end else if (r_reg.tmr == K_TMO_END) begin
				// silent device: report and still keep the turnaround
				r_next.rsp_err = 1'b1;
				r_next.st = H_TURN;
				r_next.tmr = '0;
			end
		end
		H_RX_LOW: begin
			if (rose) begin
				r_next.sh = {r_reg.tmr < K_THRESH, r_reg.sh[15:1]};
				r_next.nbit = r_reg.nbit + 4'h1;
				r_next.tmr = '0;
				r_next.st = (r_reg.nbit == 4'h7) ? H_TURN : H_WAIT_RSP;
			end
		end
		H_TURN: begin
			if (r_reg.tmr == K_TURN_END) begin
				r_next.rsp_valid = 1'b1;
				r_next.rsp_data = r_reg.sh[15:8];
				r_next.st = H_IDLE;
			end
		end
		endcase

		r_next.ready = (r_next.st == H_IDLE);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r_reg <= HOST_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign lnk.host_line_o = 1'b0;
	assign lnk.host_line_oe_n = r_reg.oe_n;
	assign req_ready = r_reg.ready;
	assign rsp_valid = r_reg.rsp_valid;
	assign rsp_data = r_reg.rsp_data;
	assign rsp_err = r_reg.rsp_err;
endmodule

`default_nettype wire

//--- testbench/swh_props.sv
// line timing checks for the single-wire port, both ends together
// assumes the interface signals and device mode outputs are wired in
`timescale 1ns/10ps
`default_nettype none

module swh_props #(
	parameter int H_ONE = 10,
	parameter int H_ZERO = 120,
	parameter int H_BREAK = 200,
	parameter int H_REL = 50,
	parameter int H_BIT = 220,
	parameter int H_TURN = 260,
	parameter int H_RESET = 3000,
	parameter int D_ONE = 40,
	parameter int D_ZERO = 112,
	parameter int D_PERIOD = 230,
	parameter int D_DELAY = 300,
	parameter int D_RESET = 2900
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic dev_line_oe_n,
	input wire logic host_line_oe_n,
	input wire logic line,
	input wire logic swire_mode,
	input wire logic link_reset
);
	localparam int SAT = 100000;
	int h_lo, h_hi, h_last, d_lo, d_hi, d_since, l_lo;

	// ----------------------------------------------------------------
	// run-length counters
	// ----------------------------------------------------------------
	// idle counts start saturated so the first break is not a short gap
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			h_lo <= 0;
			h_hi <= SAT;
			h_last <= 0;
			d_lo <= 0;
			d_hi <= SAT;
			d_since <= SAT;
			l_lo <= 0;
		end else begin
			h_lo <= host_line_oe_n ? 0 : h_lo + 1;
			h_hi <= !host_line_oe_n ? 0 : (h_hi < SAT ? h_hi + 1 : SAT);
			h_last <= host_line_oe_n ? h_last : h_lo + 1;
			d_lo <= dev_line_oe_n ? 0 : d_lo + 1;
			d_hi <= !dev_line_oe_n ? 0 : (d_hi < SAT ? d_hi + 1 : SAT);
			d_since <= $fell(dev_line_oe_n) ? 0 :
				(d_since < SAT ? d_since + 1 : SAT);
			l_lo <= line ? 0 : l_lo + 1;
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_first_reply;
		$fell(dev_line_oe_n) && d_since >= 2 * D_PERIOD;
	endsequence
	sequence s_next_reply;
		$fell(dev_line_oe_n) && d_since < 2 * D_PERIOD;
	endsequence
	sequence s_break_end;
		$fell(host_line_oe_n) && h_last >= H_BREAK - 1 &&
			h_last <= H_BREAK + 1;
	endsequence

	host_pulse_a: assert property ($rose(host_line_oe_n) |->
		h_lo inside {[H_ONE-1:H_ONE+1], [H_ZERO-1:H_ZERO+1],
		[H_BREAK-1:H_BREAK+1], [H_RESET-1:H_RESET+1]})
		else $error("host low pulse length out of class");
	break_rel_a: assert property (s_break_end |->
		h_hi inside {[H_REL-1:H_REL+1]} && h_last <= H_BREAK + 1)
		else $error("break release length wrong");
	host_period_a: assert property ($fell(host_line_oe_n) |->
		h_last + h_hi >= H_BIT - 1)
		else $error("host bit period too short");
	reply_delay_a: assert property (s_first_reply |->
		h_hi inside {[D_DELAY:D_DELAY+8]})
		else $error("reply delay out of range");
	reply_pulse_a: assert property ($rose(dev_line_oe_n) |->
		d_lo inside {[D_ONE-1:D_ONE+1], [D_ZERO-1:D_ZERO+1]})
		else $error("reply pulse length out of class");
	reply_period_a: assert property (s_next_reply |->
		d_since inside {[D_PERIOD-2:D_PERIOD+1]})
		else $error("reply bit period wrong");
	turn_gap_a: assert property ($fell(host_line_oe_n) |->
		d_hi >= H_TURN - 1)
		else $error("host drove too soon after reply");
	long_low_a: assert property ($rose(link_reset) |->
		l_lo inside {[D_RESET-1:D_RESET+5]})
		else $error("link reset not tied to long low");
	mode_quiet_a: assert property (!swire_mode |->
		dev_line_oe_n)
		else $error("device drove line outside single-wire mode");
	mode_sticky_a: assert property ($rose(swire_mode) |=>
		swire_mode [*8])
		else $error("single-wire mode was cleared");
	mode_hold_a: assert property (swire_mode |=> swire_mode)
		else $error("single-wire mode dropped");
endmodule

`default_nettype wire

//--- testbench/single_wire_host_port_tb_top.sv
// self-checking bench: host end and device end joined by one line
// assumes swh_pkg, swh_if and both ends are compiled before it
`timescale 1ns/10ps
`default_nettype none

module single_wire_host_port_tb_top;
	import swh_pkg::*;
	// ----------------------------------------------------------------
	// shortened counts; the reset low shortened far more than the others
	// ----------------------------------------------------------------
	localparam int H_BIT = 220;
	localparam int H_RESET = 3000;
	localparam int H_ONE = 10;
	localparam int H_ZERO = 120;
	localparam int H_BREAK = 200;
	localparam int H_REL = 50;
	localparam int H_TURN = 260;
	localparam int H_THRESH = 65;
	localparam int H_TMO = 1300;
	localparam int D_BREAK = 180;
	localparam int D_THRESH = 70;
	localparam int D_ONE = 40;
	localparam int D_ZERO = 112;
	localparam int D_PERIOD = 230;
	localparam int D_DELAY = 300;
	// device break and reset below the host's so edge slips cannot miss
	localparam int D_RESET = 2900;
	logic sys_clk, sys_rst, req_valid, req_write, force_reset, swire_mode_set;
	swh_addr_t req_addr, addr, cap_addr;
	swh_byte_t req_data, rd_data, rsp_data, wr_data, cap_data, got_data;
	logic swire_mode, rd_req, wr_valid, link_reset, req_ready, rsp_valid;
	logic rsp_err, got_err;
	int mismatches, n_compared, n_wr, n_rd, n_lr;

	swh_if u_swh_if();
	swh_dev #(.BREAK_CYC(D_BREAK), .THRESH_CYC(D_THRESH),
		.DELAY_CYC(D_DELAY), .ONE_CYC(D_ONE), .ZERO_CYC(D_ZERO),
		.PERIOD_CYC(D_PERIOD),
		.RESET_CYC(D_RESET)) u_swh_dev(.sys_clk(sys_clk),
		.sys_rst(sys_rst), .lnk(u_swh_if.dev),
		.swire_mode_set(swire_mode_set), .rd_data(rd_data),
		.swire_mode(swire_mode), .rd_req(rd_req), .wr_valid(wr_valid),
		.addr(addr), .wr_data(wr_data), .link_reset(link_reset));
	swh_host #(.BREAK_CYC(H_BREAK), .REL_CYC(H_REL), .ONE_CYC(H_ONE),
		.ZERO_CYC(H_ZERO), .BIT_CYC(H_BIT), .THRESH_CYC(H_THRESH),
		.TMO_CYC(H_TMO),
		.TURN_CYC(H_TURN), .RESET_CYC(H_RESET)) u_swh_host(
		.sys_clk(sys_clk), .sys_rst(sys_rst), .lnk(u_swh_if.host),
		.req_valid(req_valid), .req_write(req_write),
		.req_addr(req_addr), .req_data(req_data),
		.force_reset(force_reset), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err));
	swh_props #(.H_ONE(H_ONE), .H_ZERO(H_ZERO), .H_BREAK(H_BREAK),
		.H_REL(H_REL), .H_BIT(H_BIT), .H_TURN(H_TURN),
		.H_RESET(H_RESET), .D_ONE(D_ONE), .D_ZERO(D_ZERO),
		.D_PERIOD(D_PERIOD), .D_DELAY(D_DELAY), .D_RESET(D_RESET))
		u_swh_props(.sys_clk(sys_clk), .sys_rst(sys_rst),
		.dev_line_oe_n(u_swh_if.dev_line_oe_n),
		.host_line_oe_n(u_swh_if.host_line_oe_n), .line(u_swh_if.line),
		.swire_mode(swire_mode), .link_reset(link_reset));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	always @(negedge sys_clk) begin
		if (wr_valid === 1'b1) begin
			n_wr++;
			cap_addr = addr;
			cap_data = wr_data;
		end
		if (rd_req === 1'b1) begin
			n_rd++;
			cap_addr = addr;
		end
		if (link_reset === 1'b1)
			n_lr++;
	end

	task automatic chk(input string name, input logic [7:0] exp,
		input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 10000) begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 10000)
			chk("req_ready", 8'h01, 8'h00);
	endtask

	// drive at a negedge with ready high, so the next posedge takes it
	task automatic xfer(input logic w, input swh_addr_t a,
		input swh_byte_t d);
		int n;
		n_wr = 0;
		n_rd = 0;
		@(negedge sys_clk);
		wait_ready();
		req_write = w;
		req_addr = a;
		req_data = d;
		req_valid = 1'b1;
		@(negedge sys_clk);
		req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 8000) begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 8000)
			chk("rsp_valid", 8'h01, 8'h00);
		got_data = rsp_data;
		got_err = rsp_err;
	endtask

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_unset();
		xfer(1'b1, 7'h5A, 8'hC3);
		chk("wr_count", 8'h00, n_wr[7:0]);
		xfer(1'b0, 7'h12, 8'h00);
		chk("rsp_err", 8'h01, {7'h00, got_err});
		chk("rd_count", 8'h00, n_rd[7:0]);
		chk("swire_mode", 8'h00, {7'h00, swire_mode});
		$display("test unset done");
	endtask

	task automatic t_write(input swh_addr_t a, input swh_byte_t d);
		xfer(1'b1, a, d);
		chk("wr_count", 8'h01, n_wr[7:0]);
		chk("wr_addr", {1'b0, a}, {1'b0, cap_addr});
		chk("wr_data", d, cap_data);
		chk("rsp_err", 8'h00, {7'h00, got_err});
		$display("test write %h done", a);
	endtask

	task automatic t_read(input swh_addr_t a, input swh_byte_t d);
		rd_data = d;
		xfer(1'b0, a, 8'hFF);
		chk("rd_count", 8'h01, n_rd[7:0]);
		chk("rd_addr", {1'b0, a}, {1'b0, cap_addr});
		chk("rsp_data", d, got_data);
		chk("rsp_err", 8'h00, {7'h00, got_err});
		$display("test read %h done", a);
	endtask

	task automatic t_reset();
		n_lr = 0;
		@(negedge sys_clk);
		wait_ready();
		force_reset = 1'b1;
		@(negedge sys_clk);
		force_reset = 1'b0;
		wait_ready();
		chk("link_reset", 8'h01, n_lr[7:0]);
		chk("swire_mode", 8'h01, {7'h00, swire_mode});
		$display("test reset done");
	endtask

	initial begin
		sys_rst = 1'b1;
		{req_valid, req_write, force_reset, swire_mode_set} = 4'h0;
		req_addr = 7'h00;
		req_data = 8'h00;
		rd_data = 8'h00;
		{mismatches, n_compared, n_wr, n_rd, n_lr} = '0;
		repeat (12) @(negedge sys_clk);
		sys_rst = 1'b0;
		t_unset();
		swire_mode_set = 1'b1;
		@(negedge sys_clk);
		swire_mode_set = 1'b0;
		t_write(7'h5A, 8'hC3);
		t_read(7'h33, 8'hA5);
		t_write(7'h7F, 8'h01);
		t_read(7'h00, 8'h80);
		t_reset();
		t_read(7'h55, 8'h3C);
		summarize();
	end

	// about 30000 cycles of traffic, twice that before giving up
	initial begin
		repeat (60000) @(posedge sys_clk);
		mismatches++;
		summarize();
	end
endmodule

`default_nettype wire
